/* File: logic/smr_pkg.sv */
// Constants and types for the serial memory slave
package smr_pkg;
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int PAGE_BYTES = 32;
  localparam logic [3:0] CTRL_CODE = 4'h0a;
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
  localparam logic [4:0] PAGE_STEP = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Write time per byte, in microseconds, and clock rate
  localparam int BYTE_WR_US = 50;
  localparam int CLK_MHZ = 50;
  localparam logic [11:0] BYTE_WR_CYC = 12'(BYTE_WR_US * CLK_MHZ);
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_TX,
    S_MACK,
    S_MACKED
  } smr_state_e;

  typedef enum logic [1:0] {
    K_CTRL,
    K_AHI,
    K_ALO,
    K_DATA
  } smr_kind_e;
endpackage

/* File: logic/smr_serial_memory.sv */
// Two-wire serial memory slave with write protect, busy polling and reads
// Functional notes
// - Protect input high blocks all array writes; low allows them.
// - Protect input sampled once at the STOP ending a write command.
// - No acknowledge to any control byte while the write cycle runs.
// - STOP ending a write starts the self-timed write cycle.
// - Read begins like a write, direction bit set to one.
// - Pointer holds last accessed location plus one.
// - Read pointer rolls over from top location to zero.
// - Matching read control byte is acknowledged, then byte at pointer shifted out.
// - Master ends read with no-ack and STOP; device releases data line.
// - Repeated START after address bytes abandons the write, keeps the pointer.
// - Read control byte after repeated START returns byte at loaded address.
// - After a random read the pointer sits past the byte read.
// - Each master acknowledge shifts out the next sequential byte.
// - Pointer increments on each master acknowledge and on terminating STOP.
// - Control byte: fixed code, three chip-select bits versus straps, direction.
// - Write control byte followed by high then low address byte, twelve bits.
// - Protected write fully acknowledged, no write cycle, pointer still updated.
// - Write pointer increment wraps within the current 32-byte page.
`timescale 1ns/1ns
module smr_serial_memory
  import smr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic writeProtect,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  output logic writeBusy
);

  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sclD;
    logic sdaS1;
    logic sdaS2;
    logic sdaD;
    logic wpS1;
    logic wpS2;
    logic [2:0] csS1;
    logic [2:0] csS2;
    smr_state_e st;
    smr_kind_e kind;
    logic [3:0] bitCnt;
    logic [7:0] shreg;
    logic rwRead;
    logic [3:0] addrHi;
    logic [ADDR_W-1:0] ptr;
    logic wrOpen;
    logic readOpen;
    logic [PAGE_BYTES-1:0] pageVal;
    logic [PAGE_BYTES-1:0][7:0] pageDat;
    logic busy;
    logic [11:0] wrTimer;
    logic [5:0] wrLeft;
    logic reading;
    logic [ADDR_W-1:0] fetchAddr;
    logic [1:0][7:0] fifo;
    logic fifoWr;
    logic fifoRd;
    logic [1:0] fifoCnt;
    logic sdaOe;
  } smr_state_s;

  smr_state_s r_reg;
  smr_state_s r_next;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] memRd;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic commitNow;

  // Population count of the page valid mask
  function automatic logic [5:0] countOnes(input logic [PAGE_BYTES-1:0] v);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      c = c + {5'h00, v[i]};
    end
    return c;
  endfunction

  // Bus events from the synchronised lines
  assign sclRise = r_reg.sclS2 & ~r_reg.sclD;
  assign sclFall = ~r_reg.sclS2 & r_reg.sclD;
  assign startSeen = r_reg.sclS2 & r_reg.sclD & r_reg.sdaD & ~r_reg.sdaS2;
  assign stopSeen = r_reg.sclS2 & r_reg.sclD & ~r_reg.sdaD & r_reg.sdaS2;
  assign commitNow = r_reg.busy && (r_reg.wrLeft == 6'h01) && (r_reg.wrTimer == 12'h000);
  assign memRd = mem[r_reg.fetchAddr];

  // Open-drain data line
  assign sdaOut = 1'b0;
  assign sdaOe = r_reg.sdaOe;
  assign writeBusy = r_reg.busy;

  // Next-state logic
  always_comb
  begin
    logic push;
    logic pop;
    logic flush;
    logic ackIt;
    logic match;
    logic [7:0] popData;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    ackIt = 1'b0;
    match = 1'b0;
    popData = (r_reg.fifoCnt != 2'h0) ? r_reg.fifo[r_reg.fifoRd] : IDLE_BYTE;
    r_next = r_reg;
    // Two-flop synchronisers and edge history
    r_next.sclS1 = scl;
    r_next.sclS2 = r_reg.sclS1;
    r_next.sclD = r_reg.sclS2;
    r_next.sdaS1 = sdaIn;
    r_next.sdaS2 = r_reg.sdaS1;
    r_next.sdaD = r_reg.sdaS2;
    r_next.wpS1 = writeProtect;
    r_next.wpS2 = r_reg.wpS1;
    r_next.csS1 = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
    r_next.csS2 = r_reg.csS1;

    // Self-timed write cycle, one slot per stored byte
    if (r_reg.busy)
    begin
      if (r_reg.wrTimer == 12'h000)
      begin
        r_next.wrTimer = BYTE_WR_CYC - 12'h001;
        r_next.wrLeft = r_reg.wrLeft - 6'h01;
        if (r_reg.wrLeft == 6'h01)
          r_next.busy = 1'b0;
      end
      else
        r_next.wrTimer = r_reg.wrTimer - 12'h001;
    end

    if (startSeen)
    begin
      // Repeated START drops any pending write data, pointer stays
      r_next.st = S_RX;
      r_next.kind = K_CTRL;
      r_next.bitCnt = 4'h0;
      r_next.sdaOe = 1'b0;
      r_next.wrOpen = 1'b0;
      r_next.readOpen = 1'b0;
      r_next.reading = 1'b0;
      flush = 1'b1;
    end
    else if (stopSeen)
    begin
      // Protect sampled here only
      if (r_reg.wrOpen && (r_reg.pageVal != '0) && !r_reg.wpS2)
      begin
        r_next.busy = 1'b1;
        r_next.wrLeft = countOnes(r_reg.pageVal);
        r_next.wrTimer = BYTE_WR_CYC - 12'h001;
      end
      // Terminating STOP after a read steps the pointer
      if (r_reg.readOpen)
        r_next.ptr = r_reg.ptr + PTR_STEP;
      r_next.st = S_IDLE;
      r_next.sdaOe = 1'b0;
      r_next.wrOpen = 1'b0;
      r_next.readOpen = 1'b0;
      r_next.reading = 1'b0;
      flush = 1'b1;
    end
    else
    begin
      unique case (r_reg.st)
        S_IDLE:
        begin
          r_next.sdaOe = 1'b0;
        end
        S_RX:
        begin
          if (sclRise)
          begin
            r_next.shreg = {r_reg.shreg[6:0], r_reg.sdaS2};
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
          end
          else if (sclFall && (r_reg.bitCnt == BITS_PER_BYTE))
          begin
            unique case (r_reg.kind)
              K_CTRL:
              begin
                // Code and straps must match, silent while busy
                match = (r_reg.shreg[7:4] == CTRL_CODE) && (r_reg.shreg[3:1] == r_reg.csS2);
                if (match && !r_reg.busy)
                begin
                  ackIt = 1'b1;
                  r_next.rwRead = r_reg.shreg[0];
                  if (r_reg.shreg[0])
                  begin
                    r_next.reading = 1'b1;
                    r_next.fetchAddr = r_reg.ptr;
                    flush = 1'b1;
                  end
                end
                else
                  r_next.st = S_IDLE;
              end
              K_AHI:
              begin
                r_next.addrHi = r_reg.shreg[3:0];
                ackIt = 1'b1;
              end
              K_ALO:
              begin
                r_next.ptr = {r_reg.addrHi, r_reg.shreg};
                r_next.pageVal = '0;
                r_next.wrOpen = 1'b1;
                ackIt = 1'b1;
              end
              K_DATA:
              begin
                // Acknowledged even when protected, pointer still moves
                r_next.pageDat[r_reg.ptr[4:0]] = r_reg.shreg;
                r_next.pageVal[r_reg.ptr[4:0]] = 1'b1;
                r_next.ptr = {r_reg.ptr[11:5], r_reg.ptr[4:0] + PAGE_STEP};
                ackIt = 1'b1;
              end
            endcase
            if (ackIt)
            begin
              r_next.st = S_ACK;
              r_next.sdaOe = 1'b1;
            end
          end
        end
        S_ACK:
        begin
          if (sclFall)
          begin
            r_next.sdaOe = 1'b0;
            if ((r_reg.kind == K_CTRL) && r_reg.rwRead)
            begin
              // First read byte from the current pointer
              pop = 1'b1;
              r_next.readOpen = 1'b1;
              r_next.shreg = popData;
              r_next.sdaOe = ~popData[7];
              r_next.bitCnt = 4'h1;
              r_next.st = S_TX;
            end
            else
            begin
              r_next.st = S_RX;
              r_next.bitCnt = 4'h0;
              unique case (r_reg.kind)
                K_CTRL: r_next.kind = K_AHI;
                K_AHI: r_next.kind = K_ALO;
                K_ALO: r_next.kind = K_DATA;
                K_DATA: r_next.kind = K_DATA;
              endcase
            end
          end
        end
        S_TX:
        begin
          if (sclFall)
          begin
            if (r_reg.bitCnt == BITS_PER_BYTE)
            begin
              r_next.sdaOe = 1'b0;
              r_next.st = S_MACK;
            end
            else
            begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b0};
              r_next.sdaOe = ~r_reg.shreg[6];
              r_next.bitCnt = r_reg.bitCnt + 4'h1;
            end
          end
        end
        S_MACK:
        begin
          if (sclRise)
          begin
            if (!r_reg.sdaS2)
            begin
              // Master acknowledge steps the pointer, full wrap
              r_next.ptr = r_reg.ptr + PTR_STEP;
              r_next.st = S_MACKED;
            end
            else
              r_next.st = S_IDLE;
          end
        end
        S_MACKED:
        begin
          if (sclFall)
          begin
            // Next sequential byte
            pop = 1'b1;
            r_next.shreg = popData;
            r_next.sdaOe = ~popData[7];
            r_next.bitCnt = 4'h1;
            r_next.st = S_TX;
          end
        end
      endcase
    end

    // Two-entry read-ahead buffer; fetch stalls while it is full
    push = r_next.reading && !flush && (r_reg.fifoCnt != FIFO_DEPTH);
    if (flush)
    begin
      r_next.fifoCnt = 2'h0;
      r_next.fifoWr = 1'b0;
      r_next.fifoRd = 1'b0;
    end
    else
    begin
      if (push)
      begin
        r_next.fifo[r_reg.fifoWr] = memRd;
        r_next.fifoWr = ~r_reg.fifoWr;
        r_next.fetchAddr = r_reg.fetchAddr + PTR_STEP;
      end
      if (pop && (r_reg.fifoCnt != 2'h0))
        r_next.fifoRd = ~r_reg.fifoRd;
      r_next.fifoCnt = r_reg.fifoCnt + {1'b0, push} - {1'b0, pop && (r_reg.fifoCnt != 2'h0)};
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.sclS1 <= 1'b1;
      r_reg.sclS2 <= 1'b1;
      r_reg.sclD <= 1'b1;
      r_reg.sdaS1 <= 1'b1;
      r_reg.sdaS2 <= 1'b1;
      r_reg.sdaD <= 1'b1;
      r_reg.st <= S_IDLE;
      r_reg.kind <= K_CTRL;
      r_reg.ptr <= PTR_RESET;
    end
    else
      r_reg <= r_next;
  end

  // Array update at the end of an unprotected write cycle
  always_ff @(posedge clk)
  begin
    if (commitNow)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (r_reg.pageVal[i])
          mem[{r_reg.ptr[11:5], 5'(i)}] <= r_reg.pageDat[i];
      end
    end
  end

endmodule // smr_serial_memory

/* File: tb/smr_checker.sv */
// Port-level assertions for the serial memory slave
`timescale 1ns/1ns
module smr_checker
  import smr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic writeProtect,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  input wire logic writeBusy
);
  logic sclPrev, sdaPrev, stopNow, wpAtStop;
  logic [3:0] sinceStop;
  logic [16:0] busyLen;
  // Raw STOP: data rises while the clock stays high
  assign stopNow = scl && sclPrev && sdaIn && !sdaPrev;
  // Edge history, cycles since STOP, protect level at STOP, busy length
  always_ff @(posedge clk)
  begin
    sclPrev <= scl;
    sdaPrev <= sdaIn;
    busyLen <= writeBusy ? busyLen + 17'h0_0001 : 17'h0_0000;
    if (rst)
      sinceStop <= 4'hf;
    else if (stopNow)
      sinceStop <= 4'h0;
    else if (sinceStop != 4'hf)
      sinceStop <= sinceStop + 4'h1;
    if (stopNow)
      wpAtStop <= writeProtect;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_drive_low: assert property (sdaOut == 1'b0) else $error("data value not low");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sdaOe && !writeBusy)
    else $error("outputs active after reset");
  a_busy_silent: assert property (writeBusy |-> !sdaOe) else $error("ack while busy");
  a_protect_idle: assert property (stopNow && writeProtect && !writeBusy |=> !writeBusy [*8])
    else $error("protected write started a cycle");
  a_busy_cause: assert property ($rose(writeBusy) |-> sinceStop < 4'h8)
    else $error("busy without STOP");
  a_busy_unprot: assert property ($rose(writeBusy) |-> !wpAtStop)
    else $error("busy though protected at STOP");
  a_busy_length: assert property ($fell(writeBusy) |-> busyLen >= 17'(BYTE_WR_CYC) - 17'h0_0001)
    else $error("write cycle too short");
  a_stop_release: assert property (stopNow |=> !sdaOe [*6])
    else $error("data driven after STOP");
endmodule // smr_checker

bind smr_serial_memory smr_checker chkr (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(writeProtect),
  .chip_select_strap_0(chip_select_strap_0), .chip_select_strap_1(chip_select_strap_1),
  .chip_select_strap_2(chip_select_strap_2), .writeBusy(writeBusy));

/* File: tb/smr_master.sv */
// Bus master model driving the serial clock and data line
`timescale 1ns/1ns
module smr_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaDrv
);
  // Both lines released and still between frames
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit: data set in low phase, sampled in high phase
  task automatic bitx(input logic b, output logic r);
    scl = 1'b0;
    w(2);
    sdaDrv = b;
    w(2);
    scl = 1'b1;
    w(2);
    r = sda;
    w(2);
  endtask
  task automatic start();
    scl = 1'b0;
    w(4);
    sdaDrv = 1'b1;
    w(2);
    scl = 1'b1;
    w(2);
    sdaDrv = 1'b0;
    w(2);
  endtask
  task automatic stop();
    scl = 1'b0;
    w(2);
    sdaDrv = 1'b0;
    w(2);
    scl = 1'b1;
    w(2);
    sdaDrv = 1'b1;
    w(2);
  endtask
  // Byte out MSB first, then the slave's acknowledge
  task automatic sendb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then acknowledge or not
  task automatic getb(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(!mack, r);
  endtask
endmodule // smr_master

/* File: tb/smr_serial_memory_bench.sv */
// Self-checking bench for the serial memory slave
`timescale 1ns/1ns
module smr_serial_memory_bench
  import smr_pkg::*;
;
  logic clk, rst, wp, ack, sda, scl, sdaDrv, sdaOe, sdaOut, busy;
  logic [2:0] strap;
  logic [7:0] mem [4096];
  logic [11:0] ptr;
  logic [31:0] seed;
  int errCount, nTests, cyc, n;
  assign sda = sdaDrv & ~sdaOe; // Pull-up wire
  smr_serial_memory dut (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .writeProtect(wp), .chip_select_strap_0(strap[0]),
    .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]), .writeBusy(busy));
  smr_master m (.clk(clk), .sda(sda), .scl(scl), .sdaDrv(sdaDrv));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic endSim();
    if (errCount == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      errCount++;
      endSim();
    end
  end
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    nTests++;
    if (e !== g)
    begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [11:0] pageNext(input logic [11:0] a);
    return {a[11:5], a[4:0] + 5'h01};
  endfunction
  task automatic cmd(input logic rw);
    m.start();
    m.sendb({CTRL_CODE, strap, rw}, ack);
  endtask
  task automatic setAddr(input logic [11:0] a);
    cmd(1'b0);
    m.sendb({4'h0, a[11:8]}, ack);
    m.sendb(a[7:0], ack);
    ptr = a;
  endtask
  // Page write of random bytes at the protect level given
  task automatic wr(input logic [11:0] a, input int cnt, input logic p);
    wp = p;
    setAddr(a);
    repeat (cnt)
    begin
      seed = xs(seed);
      m.sendb(seed[7:0], ack);
      chk("data ack", 8'h01, {7'h0, ack});
      if (!p) mem[ptr] = seed[7:0];
      ptr = pageNext(ptr);
    end
    m.stop();
  endtask
  task automatic poll(output int k);
    k = 0;
    ack = 1'b0;
    while (!ack && k < 400)
    begin
      cmd(1'b0);
      m.stop();
      k++;
    end
    chk("poll ack", 8'h01, {7'h0, ack});
  endtask
  // Read bytes from the pointer, or after loading an address
  task automatic rd(input logic [11:0] a, input int cnt, input logic ld);
    logic [7:0] d;
    if (ld) setAddr(a);
    cmd(1'b1);
    chk("read ack", 8'h01, {7'h0, ack});
    for (int i = 1; i <= cnt; i++)
    begin
      m.getb(i < cnt, d);
      chk("read byte", mem[ptr], d);
      ptr = ptr + 12'h001;
    end
    m.stop();
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    wp = 1'b0;
    errCount = 0;
    nTests = 0;
    cyc = 0;
    seed = xs(32'h0000_7784);
    strap = seed[2:0];
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    wr(12'h000, 2, 1'b0);
    poll(n);
    chk("busy polls", 8'h01, {7'h0, n > 1});
    // Mid-run reset keeps the array and clears the pointer
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    ptr = 12'h000;
    repeat (4) @(negedge clk);
    rd(12'h000, 1, 1'b0);
    wr(12'hffe, 4, 1'b0);
    poll(n);
    rd(12'hffe, 3, 1'b1);
    rd(12'h000, 1, 1'b0);
    rd(12'hfe0, 2, 1'b1);
    wr(12'h000, 1, 1'b1);
    poll(n);
    chk("protected polls", 8'h01, n[7:0]);
    rd(12'h000, 1, 1'b0);
    rd(12'h000, 1, 1'b1);
    wr(12'h001, 1, 1'b0);
    repeat (70) @(negedge clk);
    wp = 1'b1;
    poll(n);
    wp = 1'b0;
    rd(12'h001, 1, 1'b1);
    // Foreign control bytes get no acknowledge
    for (int i = 0; i < 4; i++)
    begin
      m.start();
      m.sendb(i < 3 ? {CTRL_CODE, strap ^ (3'h1 << i), 1'b1} : {4'h5, strap, 1'b1}, ack);
      m.stop();
      chk("foreign ack", 8'h00, {7'h0, ack});
    end
    endSim();
  end
endmodule // smr_serial_memory_bench
